/* File: design/spicsp_pkg.sv */
// constants and types shared by the clock-stop serial port
package spicsp_pkg;

    // clock-stop mode encodings (clock polarity 0 only)
    localparam logic [1:0] MODE_10 = 2'h2;
    localparam logic [1:0] MODE_11 = 2'h3;

    // cpu clock, 40 ns period
    localparam int CPU_PERIOD_NS = 40;

    // internal rate clock is one quarter of the cpu clock
    localparam int RATE_INT_DIV = 4;
    // half of it: the generator counts half input periods
    localparam int HALF_TICK_CYC = RATE_INT_DIV / 2;

    // settings software must program while a slave
    localparam logic       SLV_SRC_SEL = 1'h1;
    localparam logic [7:0] SLV_DIVIDER = 8'h01;

    // slave output enable after select, in cpu periods (8P..16P)
    localparam int SLV_EN_DLY_NS  = 8 * CPU_PERIOD_NS;
    localparam int SLV_EN_DLY_CYC = (SLV_EN_DLY_NS + CPU_PERIOD_NS - 1)
                                    / CPU_PERIOD_NS;
    // slave output release after deselect, in cpu periods (4P..12P)
    localparam int SLV_DIS_DLY_NS  = 4 * CPU_PERIOD_NS;
    localparam int SLV_DIS_DLY_CYC = (SLV_DIS_DLY_NS + CPU_PERIOD_NS - 1)
                                     / CPU_PERIOD_NS;

    // reset values of the frame sync and bit clock pin state
    localparam logic FRAME_PIN_RST = 1'h1;
    localparam logic CLK_PIN_RST   = 1'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_LEAD = 3'h1,
        ST_HIGH = 3'h3,
        ST_LOW  = 3'h2,
        ST_TAIL = 3'h6,
        SL_ARM  = 3'h4,
        SL_RUN  = 3'h5,
        SL_REL  = 3'h7
    } spicsp_state_t;

endpackage

/* File: design/spicsp_port.sv */
// clock-stop (spi) serial port, master or slave, one cpu clock domain
// Overview of operation
// R1: slave uses rate source 1 and divider 1, i.e. rate clock at cpu/4
// R2: rate input period is 4 cpu periods, or the external rate clock
// R3: bit clock period equals (divider+1) rate input periods
// R4: high phase is divider/2+1 if even, (divider+1)/2 if odd or zero
// R5: low phase is divider/2 if even, (divider+1)/2 if odd or zero
// R6: frame polarities 1; master frame sync out becomes active-low enable
// R7: slave inverts active-low enables on both frame sync pins
// R8: master: transmit clock and frame sync outputs, receive pins inputs
// R9: slave: all clock and frame sync directions are inputs
// R10: enable goes low before first rising edge; transfer starts rising
// R11: mode 10: data changes after rising edge, captured on falling
// R12: mode 11: data changes after falling edge, captured on rising
// R13: master 10: rise one low phase after enable; hold one period after
// R14: master 11: rise one period after enable; hold one low phase after
// R15: slave releases output 4 to 12 cpu periods after deselect
// R16: slave first output bit valid 8 to 16 cpu periods after select
// R17: all logic on cpu clock, soft reset returns everything to idle
`timescale 1ns/1ps
`default_nettype none

module spicsp_port
    import spicsp_pkg::*;
#(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    input  wire logic         soft_rst,
    // configuration
    input  wire logic         is_master,
    input  wire logic [1:0]   clock_stop_mode_sel,
    input  wire logic         rate_gen_src_sel,
    input  wire logic [7:0]   rate_gen_divider,
    input  wire logic         tx_frame_polarity,
    input  wire logic         rx_frame_polarity,
    // user side
    input  wire logic         tx_start,
    input  wire logic [W-1:0] tx_word,
    output logic              busy,
    output logic [W-1:0]      rx_word,
    output logic              rx_valid,
    output logic              rate_cfg_err,
    // direction bits
    output logic              tx_clock_dir,
    output logic              rx_clock_dir,
    output logic              tx_frame_dir,
    output logic              rx_frame_dir,
    // pins
    input  wire logic         ext_rate_clock,
    input  wire logic         tx_bit_clock_i,
    output logic              tx_bit_clock_o,
    output logic              tx_bit_clock_oe,
    input  wire logic         rx_bit_clock_i,
    input  wire logic         tx_frame_sync_i,
    output logic              tx_frame_sync_o,
    output logic              tx_frame_sync_oe,
    input  wire logic         rx_frame_sync_i,
    output logic              serial_out,
    output logic              serial_out_oe,
    input  wire logic         serial_in
);

    localparam int BW = $clog2(W + 1);

    typedef struct packed {
        spicsp_state_t st;
        logic          pre;
        logic          ext_q;
        logic          txc_q;
        logic          rxc_q;
        logic [8:0]    cnt;
        logic [3:0]    dly;
        logic [BW-1:0] bitn;
        logic [W-1:0]  sh;
        logic [W-1:0]  rsh;
        logic          first;
        logic          frame;
        logic          busy;
        logic [W-1:0]  rx_word;
        logic          rx_valid;
        logic          cfg_err;
        logic [3:0]    dirs;
        logic          clk_pin;
        logic          fs_pin;
        logic          sout;
        logic          sout_oe;
    } spicsp_regs_t;

    localparam spicsp_regs_t REGS_RST = '{
        st: ST_IDLE, fs_pin: FRAME_PIN_RST, clk_pin: CLK_PIN_RST,
        default: '0
    };

    // phase lengths in half rate-input periods
    function automatic logic [8:0] hi_len(input logic [7:0] d);
        if (d != 8'h00 && !d[0])
            hi_len = {1'b0, d} + 9'h002; // R4
        else
            hi_len = {1'b0, d} + 9'h001; // R4
    endfunction

    function automatic logic [8:0] lo_len(input logic [7:0] d);
        if (d != 8'h00 && !d[0])
            lo_len = {1'b0, d}; // R5
        else
            lo_len = {1'b0, d} + 9'h001; // R5
    endfunction

    spicsp_regs_t r_r;
    spicsp_regs_t r_nxt;

    logic       src_eff;
    logic [7:0] div_eff;
    logic       ht;
    logic [8:0] hlen;
    logic [8:0] llen;
    logic       mode11;
    logic       tx_sel;
    logic       rx_sel;
    logic       txc_rise;
    logic       txc_fall;
    logic       rxc_rise;
    logic       rxc_fall;
    logic       last_bit;

    always_comb begin
        r_nxt = r_r;
        r_nxt.rx_valid = 1'b0;
        // slave runs the generator at cpu/4 whatever is programmed
        src_eff = is_master ? rate_gen_src_sel : SLV_SRC_SEL; // R1
        div_eff = is_master ? rate_gen_divider : SLV_DIVIDER; // R1
        r_nxt.cfg_err = !is_master && (rate_gen_src_sel != SLV_SRC_SEL
                        || rate_gen_divider != SLV_DIVIDER); // R1
        // half ticks: every 2 cpu cycles, or each external clock edge
        r_nxt.ext_q = ext_rate_clock;
        if (src_eff) begin
            r_nxt.pre = ~r_r.pre; // R2
            ht = r_r.pre; // R2
        end else begin
            r_nxt.pre = 1'b0;
            ht = ext_rate_clock ^ r_r.ext_q; // R2
        end
        hlen = hi_len(div_eff);
        llen = lo_len(div_eff);
        mode11 = clock_stop_mode_sel == MODE_11;
        // slave enables are active low on the pins
        tx_sel = tx_frame_sync_i ^ tx_frame_polarity; // R7
        rx_sel = rx_frame_sync_i ^ rx_frame_polarity; // R7
        r_nxt.txc_q = tx_bit_clock_i;
        r_nxt.rxc_q = rx_bit_clock_i;
        txc_rise = tx_bit_clock_i && !r_r.txc_q;
        txc_fall = !tx_bit_clock_i && r_r.txc_q;
        rxc_rise = rx_bit_clock_i && !r_r.rxc_q;
        rxc_fall = !rx_bit_clock_i && r_r.rxc_q;
        last_bit = r_r.bitn == BW'(W - 1);
        r_nxt.dirs = is_master ? 4'hA : 4'h0; // R8 R9

        unique case (r_r.st)
            ST_IDLE: begin
                if (is_master && tx_start && clock_stop_mode_sel[1]) begin
                    r_nxt.st = ST_LEAD;
                    r_nxt.frame = 1'b1; // R10
                    r_nxt.busy = 1'b1;
                    r_nxt.cnt = '0;
                    r_nxt.bitn = '0;
                    r_nxt.sout_oe = 1'b1;
                    if (mode11) begin
                        r_nxt.sout = tx_word[W-1]; // R12
                        r_nxt.sh = tx_word << 1;
                    end else begin
                        r_nxt.sh = tx_word;
                    end
                end else if (!is_master && tx_start) begin
                    // slave preloads its word ahead of selection
                    r_nxt.sh = tx_word;
                end else if (!is_master && tx_sel) begin
                    r_nxt.st = SL_ARM;
                    r_nxt.busy = 1'b1;
                    r_nxt.dly = '0;
                    r_nxt.bitn = '0;
                end
            end
            ST_LEAD, ST_LOW: begin
                if (ht) begin
                    r_nxt.cnt = r_r.cnt + 9'h001;
                    // lead is one low phase in 10, a full period in 11
                    if ((r_r.st == ST_LEAD && mode11 &&
                         r_r.cnt == hlen + llen - 9'h001) || // R14
                        ((r_r.st == ST_LOW || !mode11) &&
                         r_r.cnt == llen - 9'h001)) begin // R13 R5
                        r_nxt.st = ST_HIGH;
                        r_nxt.cnt = '0;
                        r_nxt.clk_pin = 1'b1; // R10
                        if (mode11) begin
                            r_nxt.rsh = {r_r.rsh[W-2:0], serial_in}; // R12
                        end else begin
                            r_nxt.sout = r_r.sh[W-1]; // R11
                            r_nxt.sh = r_r.sh << 1;
                        end
                    end
                end
            end
            ST_HIGH: begin
                if (ht) begin
                    r_nxt.cnt = r_r.cnt + 9'h001;
                    if (r_r.cnt == hlen - 9'h001) begin // R4 R3
                        r_nxt.clk_pin = 1'b0;
                        r_nxt.cnt = '0;
                        r_nxt.bitn = r_r.bitn + BW'(1);
                        r_nxt.st = last_bit ? ST_TAIL : ST_LOW;
                        if (!mode11) begin
                            r_nxt.rsh = {r_r.rsh[W-2:0], serial_in}; // R11
                        end else if (!last_bit) begin
                            r_nxt.sout = r_r.sh[W-1]; // R12
                            r_nxt.sh = r_r.sh << 1;
                        end
                    end
                end
            end
            ST_TAIL: begin
                if (ht) begin
                    r_nxt.cnt = r_r.cnt + 9'h001;
                    if ((!mode11 && r_r.cnt == hlen + llen - 9'h001) || // R13
                        (mode11 && r_r.cnt == llen - 9'h001)) begin // R14
                        r_nxt.st = ST_IDLE;
                        r_nxt.frame = 1'b0;
                        r_nxt.sout_oe = 1'b0;
                        r_nxt.busy = 1'b0;
                        r_nxt.rx_word = r_r.rsh;
                        r_nxt.rx_valid = 1'b1;
                    end
                end
            end
            SL_ARM, SL_RUN: begin
                // capture uses the receive clock, gated by its own enable
                if (rx_sel && !r_r.bitn[BW-1 -: 1] | (r_r.bitn < BW'(W))) begin
                    if ((mode11 && rxc_rise) || (!mode11 && rxc_fall)) begin
                        r_nxt.rsh = {r_r.rsh[W-2:0], serial_in}; // R11 R12
                        r_nxt.bitn = r_r.bitn + BW'(1);
                        if (last_bit) begin
                            r_nxt.rx_word = {r_r.rsh[W-2:0], serial_in};
                            r_nxt.rx_valid = 1'b1;
                        end
                    end
                end
                if (r_r.st == SL_ARM) begin
                    r_nxt.dly = r_r.dly + 4'h1;
                    if (r_r.dly == 4'(SLV_EN_DLY_CYC - 1)) begin // R16
                        r_nxt.st = SL_RUN;
                        r_nxt.sout = r_r.sh[W-1];
                        r_nxt.sh = r_r.sh << 1;
                        r_nxt.sout_oe = 1'b1;
                        r_nxt.first = 1'b1;
                    end
                end else if (mode11 ? txc_fall : txc_rise) begin
                    // in 10 the first rising edge keeps the bit already out
                    r_nxt.first = 1'b0;
                    if (mode11 || !r_r.first) begin
                        r_nxt.sout = r_r.sh[W-1]; // R11 R12
                        r_nxt.sh = r_r.sh << 1;
                    end
                end
                if (!tx_sel) begin
                    r_nxt.st = SL_REL;
                    r_nxt.dly = '0;
                end
            end
            SL_REL: begin
                r_nxt.dly = r_r.dly + 4'h1;
                if (r_r.dly == 4'(SLV_DIS_DLY_CYC - 1)) begin // R15
                    r_nxt.st = ST_IDLE;
                    r_nxt.sout_oe = 1'b0;
                    r_nxt.busy = 1'b0;
                    r_nxt.sh = '0;
                end
            end
        endcase

        // master frame sync pin is the internal frame, inverted when tx_frame_polarity is 1
        r_nxt.fs_pin = r_nxt.frame ^ tx_frame_polarity; // R6
        if (!is_master) begin
            r_nxt.clk_pin = CLK_PIN_RST;
        end
        if (soft_rst) begin
            r_nxt = REGS_RST; // R17
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_r <= REGS_RST;
        end else begin
            r_r <= r_nxt; // R17
        end
    end

    assign busy             = r_r.busy;
    assign rx_word          = r_r.rx_word;
    assign rx_valid         = r_r.rx_valid;
    assign rate_cfg_err     = r_r.cfg_err;
    assign tx_clock_dir     = r_r.dirs[3];
    assign rx_clock_dir     = r_r.dirs[2];
    assign tx_frame_dir     = r_r.dirs[1];
    assign rx_frame_dir     = r_r.dirs[0];
    assign tx_bit_clock_o   = r_r.clk_pin;
    assign tx_bit_clock_oe  = r_r.dirs[3]; // R8 R9
    assign tx_frame_sync_o  = r_r.fs_pin;
    assign tx_frame_sync_oe = r_r.dirs[1]; // R8 R9
    assign serial_out       = r_r.sout;
    assign serial_out_oe    = r_r.sout_oe;

endmodule

`default_nettype wire

/* File: verif/spicsp_sva.sv */
// assertions on the clock-stop serial port pins
`timescale 1ns/1ps
`default_nettype none
module spicsp_sva
    import spicsp_pkg::*;
(
    // clock, reset and setup
    input wire logic       core_clk,
    input wire logic       sys_rst,
    input wire logic       soft_rst,
    input wire logic       is_master,
    input wire logic [1:0] clock_stop_mode_sel,
    input wire logic       rate_gen_src_sel,
    input wire logic [7:0] rate_gen_divider,
    input wire logic       tx_start,
    // status and pins
    input wire logic       busy,
    input wire logic       tx_clock_dir,
    input wire logic       tx_frame_dir,
    input wire logic       rx_clock_dir,
    input wire logic       rx_frame_dir,
    input wire logic       tx_bit_clock_o,
    input wire logic       tx_frame_sync_i,
    input wire logic       tx_frame_sync_o,
    input wire logic       serial_out,
    input wire logic       serial_out_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst || soft_rst);
    logic       ref_cfg;
    logic       m10;
    logic [7:0] low_run_r;
    assign ref_cfg = rate_gen_src_sel && rate_gen_divider == 8'h01;
    assign m10     = clock_stop_mode_sel == MODE_10;
    // idle-clock cycles inside a master frame, timing the tail hold
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) low_run_r <= 8'h00;
        else if (tx_bit_clock_o || tx_frame_sync_o) low_run_r <= 8'h00;
        else low_run_r <= low_run_r + 8'h01;
    end
    sequence start_s;
        tx_start && is_master && clock_stop_mode_sel[1] && !busy;
    endsequence
    sequence sel_fall_s;
        $fell(tx_frame_sync_o) && is_master && ref_cfg;
    endsequence
    dir_follow_a: assert property (
        !$past(sys_rst || soft_rst) |-> !rx_clock_dir && !rx_frame_dir &&
        tx_clock_dir == $past(is_master) && tx_frame_dir == $past(is_master))
        else $error("direction bits wrong for role");
    frame_low_a: assert property (start_s |=> busy && !tx_frame_sync_o)
        else $error("enable not driven low after start");
    lead_ten_a: assert property ((sel_fall_s and m10) |->
        !tx_bit_clock_o [*2] ##[1:5] tx_bit_clock_o)
        else $error("mode 10 lead wrong");
    lead_eleven_a: assert property ((sel_fall_s and !m10) |->
        !tx_bit_clock_o [*6] ##[1:5] tx_bit_clock_o)
        else $error("mode 11 lead wrong");
    tail_hold_a: assert property (
        $rose(tx_frame_sync_o) && is_master && ref_cfg |->
        (m10 ? low_run_r inside {[7:9]} : low_run_r inside {[3:5]}))
        else $error("enable hold after last edge wrong");
    slave_on_a: assert property (
        !is_master && !busy && $fell(tx_frame_sync_i) |->
        !serial_out_oe [*7] ##[1:9] serial_out_oe)
        else $error("slave output enable timing wrong");
    slave_off_a: assert property (
        !is_master && m10 && serial_out_oe && $rose(tx_frame_sync_i) |->
        serial_out_oe [*3] ##[1:9] !serial_out_oe)
        else $error("slave output release timing wrong");
    data_edge_a: assert property (
        is_master && serial_out_oe && $past(serial_out_oe) &&
        $changed(serial_out) |-> tx_bit_clock_o == m10)
        else $error("data changed on wrong clock edge");
    soft_idle_a: assert property (disable iff (sys_rst)
        soft_rst |=> !busy && !serial_out_oe && tx_frame_sync_o)
        else $error("soft reset left port active");
endmodule
bind spicsp_port spicsp_sva u_sva (
    .core_clk, .sys_rst, .soft_rst, .is_master, .clock_stop_mode_sel,
    .rate_gen_src_sel, .rate_gen_divider, .tx_start, .busy, .tx_clock_dir,
    .tx_frame_dir, .rx_clock_dir, .rx_frame_dir, .tx_bit_clock_o,
    .tx_frame_sync_i, .tx_frame_sync_o, .serial_out, .serial_out_oe
);
`default_nettype wire

/* File: verif/spicsp_peer.sv */
// spi slave model standing on the far side of the master port
`timescale 1ns/1ps
`default_nettype none
module spicsp_peer
    import spicsp_pkg::*;
(
    // clock, reset and mode
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic [1:0] mode,
    // spi lines and words
    input  wire logic       sel_n,
    input  wire logic       sclk,
    input  wire logic       mosi,
    output logic            miso,
    input  wire logic [7:0] tx_word,
    output logic [7:0]      rx_word
);
    logic       sclk_q;
    logic       first_q;
    logic       junk_q;
    logic [7:0] sh_q;
    // released line toggles so a stale bit can never pass for data
    assign miso = sel_n ? junk_q : sh_q[7];
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_q <= 1'b0;
            first_q <= 1'b1;
            junk_q <= 1'b0;
            sh_q <= 8'h00;
            rx_word <= 8'h00;
        end else begin
            sclk_q <= sclk;
            junk_q <= ~junk_q;
            if (sel_n) begin
                sh_q <= tx_word;
                first_q <= 1'b1;
            end else if (sclk != sclk_q) begin
                if (sclk != (mode == MODE_10)) begin
                    rx_word <= {rx_word[6:0], mosi};
                end else if (first_q && mode == MODE_10) begin
                    first_q <= 1'b0;
                end else begin
                    sh_q <= {sh_q[6:0], 1'b0};
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: verif/spicsp_port_test.sv */
// self-checking bench for the clock-stop serial port
`timescale 1ns/1ps
`default_nettype none
module spicsp_port_test
    import spicsp_pkg::*;
;
    logic core_clk, sys_rst, soft_rst, is_master, rate_gen_src_sel, tx_start;
    logic tx_frame_polarity, rx_frame_polarity, busy, rx_valid, rate_cfg_err;
    logic tx_clock_dir, rx_clock_dir, tx_frame_dir, rx_frame_dir, serial_in;
    logic ext_rate_clock, tx_bit_clock_i, tx_bit_clock_o, tx_bit_clock_oe;
    logic rx_bit_clock_i, tx_frame_sync_i, tx_frame_sync_o, tx_frame_sync_oe;
    logic rx_frame_sync_i, serial_out, serial_out_oe, peer_sdi, clk_q;
    logic tb_sdi, tb_clk, tb_sel;
    logic [1:0] clock_stop_mode_sel;
    logic [7:0] rate_gen_divider, tx_word, rx_word, peer_tx, peer_rx, got;
    int n_errors, checked, run, hi_w, lo_w, ext_cnt, n_valid;
    logic [3:0] dir_bits;
    localparam logic [7:0] DIVS [6] = '{8'h01, 8'h01, 8'h02, 8'h00, 8'h03,
                                        8'h01};
    // pin level resolved from the port's enables and the bench's drive
    assign tx_bit_clock_i  = tx_bit_clock_oe ? tx_bit_clock_o : tb_clk;
    assign tx_frame_sync_i = tx_frame_sync_oe ? tx_frame_sync_o : tb_sel;
    assign rx_bit_clock_i  = tx_bit_clock_i;
    assign rx_frame_sync_i = tx_frame_sync_i;
    assign serial_in       = is_master ? peer_sdi : tb_sdi;
    assign dir_bits = {tx_clock_dir, tx_frame_dir, rx_clock_dir, rx_frame_dir};
    spicsp_port DUT (
        .core_clk, .sys_rst, .soft_rst, .is_master, .clock_stop_mode_sel,
        .rate_gen_src_sel, .rate_gen_divider, .tx_frame_polarity,
        .rx_frame_polarity, .tx_start, .tx_word, .busy, .rx_word, .rx_valid,
        .rate_cfg_err, .tx_clock_dir, .rx_clock_dir, .tx_frame_dir,
        .rx_frame_dir, .ext_rate_clock, .tx_bit_clock_i, .tx_bit_clock_o,
        .tx_bit_clock_oe, .rx_bit_clock_i, .tx_frame_sync_i, .tx_frame_sync_o,
        .tx_frame_sync_oe, .rx_frame_sync_i, .serial_out, .serial_out_oe,
        .serial_in
    );
    spicsp_peer u_peer (.core_clk, .sys_rst, .mode(clock_stop_mode_sel),
        .sel_n(tx_frame_sync_i), .sclk(tx_bit_clock_i), .mosi(serial_out),
        .miso(peer_sdi), .tx_word(peer_tx), .rx_word(peer_rx));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // external rate clock flips every third cycle: a half tick of 3
    always @(posedge core_clk) begin
        ext_cnt <= (ext_cnt == 2) ? 0 : ext_cnt + 1;
        if (ext_cnt == 2) ext_rate_clock <= ~ext_rate_clock;
        clk_q <= tx_bit_clock_o;
        run <= (tx_bit_clock_o !== clk_q) ? 1 : run + 1;
        if (tx_bit_clock_o !== clk_q && clk_q) hi_w <= run;
        if (tx_bit_clock_o !== clk_q && !clk_q) lo_w <= run;
        if (rx_valid === 1'b1) n_valid <= n_valid + 1;
    end
    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input string what, input logic [7:0] e, logic [7:0] s);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic wait_idle;
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 1000) begin
            @(posedge core_clk);
            k++;
        end
        chk("frame end", 8'h00, {7'h0, busy});
    endtask
    task automatic start(input logic [1:0] m, input logic [7:0] w);
        @(posedge core_clk);
        clock_stop_mode_sel <= m;
        tx_word <= w;
        tx_start <= 1'b1;
        @(posedge core_clk);
        tx_start <= 1'b0;
    endtask
    task automatic master_xfer(input logic [1:0] m, input logic s,
                               input logic [7:0] d, w, input bit dup);
        int h, eh, el, v0;
        // rate input period in cpu cycles: 4 internal, 6 from the slow clock
        h = s ? 4 : 6;
        eh = (d[0] || d == 0) ? (d + 1) * h / 2 : (d / 2 + 1) * h;
        el = (d[0] || d == 0) ? (d + 1) * h / 2 : d / 2 * h;
        v0 = n_valid;
        rate_gen_src_sel <= s;
        rate_gen_divider <= d;
        peer_tx <= ~w;
        start(m, w);
        cycles(6);
        if (dup) start(m, ~w);
        wait_idle();
        chk("word in", ~w, rx_word);
        chk("word out", w, peer_rx);
        chk("high", 8'(eh), 8'(hi_w));
        chk("low", 8'(el), 8'(lo_w));
        chk("period", 8'((d + 1) * h), 8'(hi_w + lo_w));
        cycles(1);
        chk("valid pulses", 8'h01, 8'(n_valid - v0));
        $display("master test mode %h div %h done", m, d);
    endtask
    task automatic slave_xfer(input logic [1:0] m, input logic [7:0] w, r);
        int v0;
        v0 = n_valid;
        start(m, w);
        tb_sel <= 1'b0;
        cycles(20);
        for (int i = 7; i >= 0; i--) begin
            tb_sdi <= r[i];
            tb_clk <= (m == MODE_10);
            cycles(4);
            got[i] = serial_out;
            tb_clk <= (m != MODE_10);
            cycles(4);
        end
        tb_sdi <= ~r[0];
        tb_clk <= 1'b0;
        cycles(4);
        tb_sel <= 1'b1;
        cycles(2);
        wait_idle();
        chk("slave out", w, got);
        chk("slave in", r, rx_word);
        chk("released", 8'h00, {7'h0, serial_out_oe});
        chk("valid pulses", 8'h01, 8'(n_valid - v0));
        $display("slave test mode %h done", m);
    endtask
    task automatic print_verdict;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        {sys_rst, is_master, tx_frame_polarity, rx_frame_polarity} = 4'hF;
        {soft_rst, tx_start, tb_sdi, tb_clk, ext_rate_clock, clk_q} = 6'h00;
        tb_sel = 1'b1;
        rate_gen_src_sel = SLV_SRC_SEL;
        {rate_gen_divider, tx_word, peer_tx, got} = 32'h0100_0000;
        clock_stop_mode_sel = MODE_10;
        {n_errors, checked, run, hi_w, lo_w, ext_cnt, n_valid} = '0;
        cycles(8);
        sys_rst <= 1'b0;
        cycles(2);
        chk("master dirs", 8'h0C, {4'h0, dir_bits});
        for (int i = 0; i < 6; i++) begin
            master_xfer(i[0] ? MODE_11 : MODE_10, i != 5, DIVS[i],
                        8'(8'h96 + i * 8'h2B), i == 0);
        end
        start(2'h1, 8'h55);
        cycles(3);
        chk("clock stop off", 8'h00, {7'h0, busy});
        start(MODE_10, 8'h81);
        cycles(12);
        soft_rst <= 1'b1;
        cycles(2);
        soft_rst <= 1'b0;
        cycles(1);
        chk("abort", 8'h01, {6'h0, busy, tx_frame_sync_o});
        is_master <= 1'b0;
        rate_gen_src_sel <= 1'b0;
        cycles(3);
        chk("rate err", 8'h01, {7'h0, rate_cfg_err});
        rate_gen_src_sel <= SLV_SRC_SEL;
        rate_gen_divider <= SLV_DIVIDER;
        cycles(3);
        chk("rate ok", 8'h00, {7'h0, rate_cfg_err});
        chk("slave dirs", 8'h00, {4'h0, dir_bits});
        $display("config tests done");
        slave_xfer(MODE_10, 8'h3C, 8'hD2);
        slave_xfer(MODE_11, 8'hE1, 8'h4B);
        print_verdict();
    end
    initial begin
        cycles(20000);
        n_errors++;
        $display("MISMATCH watchdog expected done seen hang");
        print_verdict();
    end
endmodule
`default_nettype wire
